/* File: hw/rzh_pkg.sv */
/*
  constants, register map and state types of the return-to-zero repeater hub.
  assumes a single 50 MHz system clock and an AHB-Lite register bus.
*/
package rzh_pkg;

  // clock
  localparam int unsigned CLK_FREQ_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;

  // ports: 0 faces the center, 1..7 face satellites
  localparam int unsigned NUM_PORTS = 8;
  localparam int unsigned NUM_SAT = 7;
  localparam int unsigned NUM_PATHS = 2;
  localparam int unsigned PATH_DOWN = 0;
  localparam int unsigned PATH_UP = 1;

  // symbol timing, in clock cycles per bit
  localparam int unsigned BIT_PERIOD_W = 16;
  localparam logic [15:0] BIT_PERIOD_RST = 16'h0004;
  localparam logic [15:0] BIT_PERIOD_MIN = 16'h0004;
  localparam logic [23:0] DISTORT_PCT = 24'h000031;
  localparam logic [23:0] PCT_FULL = 24'h000064;
  localparam int unsigned MAX_LAG_BITS = 52;

  // packet ends after this many empty bit slots
  localparam logic [3:0] END_ZEROS = 4'h4;

  // error monitor pulse length
  localparam int unsigned ERR_PULSE_NS = 1_000_000;
  localparam int unsigned ERR_PULSE_CYCLES = (ERR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BAUD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ERRCNT = 8'h0c;

  // field positions
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam int unsigned STAT_ACT_LSB = 0;
  localparam int unsigned STAT_DN_BUSY_BIT = 8;
  localparam int unsigned STAT_UP_BUSY_BIT = 9;
  localparam int unsigned STAT_SEL_LSB = 12;
  localparam int unsigned STAT_DUPLEX_BIT = 16;
  localparam int unsigned ERRCNT_W = 16;

  // AHB
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    PATH_IDLE,
    PATH_RUN,
    PATH_DRAIN
  } rzh_path_e;

endpackage

/* File: hw/rzh_repeater_hub.sv */
/*
  eight-port repeater hub: regenerates return-to-zero packets cut-through,
  center port 0 to satellites 1..7 and satellites back to port 0.
  assumes pin inputs synchronous to clock, idle lines low, and one
  AHB-Lite master with hready fed back from hreadyout.
*/
// Function
// - center packet regenerated and sent to all seven satellite ports
// - one satellite packet regenerated and sent to center port only
// - while one satellite forwards, other satellites are ignored
// - duplex select high: both directions run independently
// - duplex select low: first direction wins, nothing else accepted meanwhile
// - receive-to-send lag stays within 52 bit periods
// - sending starts while packet still arrives
// - simultaneous starts: lowest numbered port served
// - full duplex: ports 0 and 1 do not contend
// - edges shifted up to 49 percent accepted and sent clean
// - distortion beyond 49 percent marks packet as error
// - error during sending stops transmission at once
// - error packet pulses error monitor output for fixed time
// - any baud rate up to 12.5 Mbps forwarded
// - activity output high while either path handles a packet
// - per-port receive activity indication for the port being forwarded only
// - port 0 upstream, ports 1 to 7 downstream
// - hubs may cascade, seven satellite ports each
// - satellite transmit enables high only while sending
// - one shared satellite transmit data output
`timescale 1ns/1ps

module rzh_repeater_hub #(
  parameter int unsigned ERR_PULSE_CYCLES = rzh_pkg::ERR_PULSE_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic duplexSelect,
  input wire logic centerRxData,
  output logic centerTxData,
  output logic centerTxEnable,
  input wire logic [6:0] satPortRxData,
  output logic [6:0] satPortTxEnable,
  output logic satSharedTxData,
  output logic activityMonitor,
  output logic [7:0] portRxActivity,
  output logic errorMonitorN
);

  // reset release
  logic rstMeta_q;
  logic rstSync_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  wire rstN = rstSync_q;

  // registers
  logic hubEnable_q;
  logic [15:0] bitPeriod_q;
  logic [rzh_pkg::ERRCNT_W-1:0] errCount_q;

  // line edges
  logic [7:0] linePrev_q;
  wire [7:0] lineNow = {satPortRxData, centerRxData};
  wire [7:0] portRise = lineNow & ~linePrev_q;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      linePrev_q <= 8'h00;
    end else begin
      linePrev_q <= lineNow;
    end
  end

  // effective timing
  wire [15:0] periodEff = (bitPeriod_q < rzh_pkg::BIT_PERIOD_MIN) ? rzh_pkg::BIT_PERIOD_MIN : bitPeriod_q;
  wire [15:0] halfPeriod = {1'b0, periodEff[15:1]};
  wire [23:0] winProd = {8'h00, periodEff} * rzh_pkg::DISTORT_PCT;
  wire [23:0] winQuot = winProd / rzh_pkg::PCT_FULL;
  wire [15:0] edgeWin = winQuot[15:0];

  function automatic logic [2:0] lowestSat(input logic [6:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = rzh_pkg::NUM_SAT - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // path arbitration
  logic [1:0] pathIdle;
  logic [1:0] pathStart;
  logic [1:0] pathRise;
  logic [1:0] pathLine;
  logic [1:0] pathErr;
  logic [1:0] pathTxData;
  logic [1:0] pathTxOn;
  logic [2:0] upSel_q;

  wire satAny = |portRise[7:1];
  assign pathStart[rzh_pkg::PATH_DOWN] = hubEnable_q && pathIdle[rzh_pkg::PATH_DOWN] && portRise[0] &&
                                         (duplexSelect || pathIdle[rzh_pkg::PATH_UP]);
  assign pathStart[rzh_pkg::PATH_UP] = hubEnable_q && pathIdle[rzh_pkg::PATH_UP] && satAny &&
                                       (duplexSelect || (pathIdle[rzh_pkg::PATH_DOWN] && !portRise[0]));

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      upSel_q <= 3'h0;
    end else if (pathStart[rzh_pkg::PATH_UP]) begin
      upSel_q <= lowestSat(portRise[7:1]);
    end
  end

  wire [2:0] upSelNow = pathStart[rzh_pkg::PATH_UP] ? lowestSat(portRise[7:1]) : upSel_q;
  // only the chosen satellite line feeds the upstream path
  assign pathLine[rzh_pkg::PATH_DOWN] = centerRxData;
  assign pathRise[rzh_pkg::PATH_DOWN] = portRise[0];
  assign pathLine[rzh_pkg::PATH_UP] = satPortRxData[upSelNow];
  assign pathRise[rzh_pkg::PATH_UP] = portRise[3'h1 + {1'b0, upSelNow[1:0]} + {upSelNow[2], 2'b00}];

  // one regenerating path per direction
  genvar p;
  for (p = 0; p < rzh_pkg::NUM_PATHS; p++) begin : gPath
    rzh_pkg::rzh_path_e st_q;
    logic [15:0] cnt_q;
    logic one_q;
    logic [15:0] highCnt_q;
    logic [3:0] zeroRun_q;
    logic [15:0] txCnt_q;
    logic txOne_q;
    logic txOn_q;
    logic txData_q;

    wire running = (st_q == rzh_pkg::PATH_RUN);
    wire edgeOk = (cnt_q <= edgeWin) || (cnt_q >= periodEff - edgeWin);
    // late edge, double edge, or line stuck high
    wire errNow = running && ((pathRise[p] && (!edgeOk || one_q)) || (highCnt_q >= periodEff));
    wire emit = running && (cnt_q == halfPeriod);
    wire lastWrap = (cnt_q == periodEff - 16'h0001);
    wire doneNow = emit && !one_q && (zeroRun_q == rzh_pkg::END_ZEROS - 4'h1);
    wire keepOn = running && !errNow && !doneNow;
    wire drainDone = (st_q == rzh_pkg::PATH_DRAIN) && !pathLine[p] && lastWrap &&
                     (zeroRun_q == rzh_pkg::END_ZEROS - 4'h1);

    always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
        st_q <= rzh_pkg::PATH_IDLE;
      end else begin
        case (st_q)
          rzh_pkg::PATH_IDLE: begin
            if (pathStart[p]) begin
              st_q <= rzh_pkg::PATH_RUN;
            end
          end
          rzh_pkg::PATH_RUN: begin
            if (errNow) begin
              st_q <= rzh_pkg::PATH_DRAIN;
            end else if (doneNow) begin
              st_q <= rzh_pkg::PATH_IDLE;
            end
          end
          rzh_pkg::PATH_DRAIN: begin
            if (drainDone) begin
              st_q <= rzh_pkg::PATH_IDLE;
            end
          end
          default: begin
            st_q <= rzh_pkg::PATH_IDLE;
          end
        endcase
      end
    end

    // slot phase, centred on the nominal rising edge
    always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
        cnt_q <= 16'h0000;
      end else if (st_q == rzh_pkg::PATH_IDLE) begin
        cnt_q <= pathStart[p] ? 16'h0001 : 16'h0000;
      end else if (st_q == rzh_pkg::PATH_DRAIN && pathLine[p]) begin
        cnt_q <= 16'h0000;
      end else begin
        cnt_q <= lastWrap ? 16'h0000 : cnt_q + 16'h0001;
      end
    end

    // edge seen for the slot now being decided
    always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
        one_q <= 1'b0;
      end else if (st_q == rzh_pkg::PATH_IDLE) begin
        one_q <= pathStart[p];
      end else if (emit) begin
        one_q <= 1'b0;
      end else if (running && pathRise[p]) begin
        one_q <= 1'b1;
      end
    end

    always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
        highCnt_q <= 16'h0000;
      end else if (st_q == rzh_pkg::PATH_IDLE) begin
        highCnt_q <= pathStart[p] ? 16'h0001 : 16'h0000;
      end else if (running && pathLine[p]) begin
        highCnt_q <= highCnt_q + 16'h0001;
      end else begin
        highCnt_q <= 16'h0000;
      end
    end

    // empty slots in a row, also low periods while draining
    always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
        zeroRun_q <= 4'h0;
      end else if (st_q == rzh_pkg::PATH_IDLE || errNow) begin
        zeroRun_q <= 4'h0;
      end else if (emit) begin
        zeroRun_q <= one_q ? 4'h0 : zeroRun_q + 4'h1;
      end else if (st_q == rzh_pkg::PATH_DRAIN) begin
        if (pathLine[p]) begin
          zeroRun_q <= 4'h0;
        end else if (lastWrap) begin
          zeroRun_q <= zeroRun_q + 4'h1;
        end
      end
    end

    // clean symbol generator, half period high for a one
    always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
        txCnt_q <= 16'h0000;
        txOne_q <= 1'b0;
      end else if (emit) begin
        txCnt_q <= 16'h0000;
        txOne_q <= one_q;
      end else if (txCnt_q < periodEff - 16'h0001) begin
        txCnt_q <= txCnt_q + 16'h0001;
      end
    end

    always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
        txOn_q <= 1'b0;
        txData_q <= 1'b0;
      end else begin
        txOn_q <= keepOn && (txOn_q || emit);
        txData_q <= keepOn && (emit ? one_q : (txOne_q && (txCnt_q + 16'h0001) < halfPeriod));
      end
    end

    assign pathIdle[p] = (st_q == rzh_pkg::PATH_IDLE);
    assign pathErr[p] = errNow;
    assign pathTxData[p] = txData_q;
    assign pathTxOn[p] = txOn_q;
  end

  assign satSharedTxData = pathTxData[rzh_pkg::PATH_DOWN];
  assign satPortTxEnable = {rzh_pkg::NUM_SAT{pathTxOn[rzh_pkg::PATH_DOWN]}};
  assign centerTxData = pathTxData[rzh_pkg::PATH_UP];
  assign centerTxEnable = pathTxOn[rzh_pkg::PATH_UP];

  // activity monitors
  logic [7:0] portAct_q;
  logic actAny_q;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      portAct_q <= 8'h00;
      actAny_q <= 1'b0;
    end else begin
      portAct_q[0] <= !pathIdle[rzh_pkg::PATH_DOWN];
      for (int i = 0; i < rzh_pkg::NUM_SAT; i++) begin
        portAct_q[i + 1] <= !pathIdle[rzh_pkg::PATH_UP] && (upSel_q == 3'(i));
      end
      actAny_q <= !pathIdle[rzh_pkg::PATH_DOWN] || !pathIdle[rzh_pkg::PATH_UP];
    end
  end
  assign portRxActivity = portAct_q;
  assign activityMonitor = actAny_q;

  // error monitor pulse
  wire anyErr = |pathErr;
  logic [31:0] errTimer_q;
  logic errN_q;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      errTimer_q <= 32'h0000_0000;
      errN_q <= 1'b1;
    end else begin
      if (anyErr) begin
        errTimer_q <= ERR_PULSE_CYCLES - 32'h0000_0001;
      end else if (errTimer_q != 32'h0000_0000) begin
        errTimer_q <= errTimer_q - 32'h0000_0001;
      end
      // low for exactly ERR_PULSE_CYCLES cycles after the error cycle
      errN_q <= !(anyErr || errTimer_q != 32'h0000_0000);
    end
  end
  assign errorMonitorN = errN_q;

  // AHB-Lite slave, zero wait states
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  wire take = hsel && hready && htrans[1];
  wire [7:0] offs = haddr[7:0];
  wire inMap = (haddr[31:8] == 24'h000000) && (offs[1:0] == 2'b00);

  function automatic logic [31:0] readReg(input logic [7:0] a, input logic mapped);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (mapped) begin
      case (a)
        rzh_pkg::REG_CTRL: v[rzh_pkg::CTRL_ENABLE_BIT] = hubEnable_q;
        rzh_pkg::REG_BAUD: v[15:0] = bitPeriod_q;
        rzh_pkg::REG_STATUS: begin
          v[rzh_pkg::STAT_ACT_LSB +: 8] = portAct_q;
          v[rzh_pkg::STAT_DN_BUSY_BIT] = !pathIdle[rzh_pkg::PATH_DOWN];
          v[rzh_pkg::STAT_UP_BUSY_BIT] = !pathIdle[rzh_pkg::PATH_UP];
          v[rzh_pkg::STAT_SEL_LSB +: 3] = upSel_q + 3'h1;
          v[rzh_pkg::STAT_DUPLEX_BIT] = duplexSelect;
        end
        rzh_pkg::REG_ERRCNT: v[rzh_pkg::ERRCNT_W-1:0] = errCount_q;
        default: v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      wrPend_q <= take && hwrite && inMap;
      wrAddr_q <= offs;
      hrdata <= (take && !hwrite) ? readReg(offs, inMap) : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      hubEnable_q <= rzh_pkg::CTRL_ENABLE_RST;
      bitPeriod_q <= rzh_pkg::BIT_PERIOD_RST;
    end else if (wrPend_q) begin
      if (wrAddr_q == rzh_pkg::REG_CTRL) begin
        hubEnable_q <= hwdata[rzh_pkg::CTRL_ENABLE_BIT];
      end
      if (wrAddr_q == rzh_pkg::REG_BAUD) begin
        bitPeriod_q <= hwdata[15:0];
      end
    end
  end

  // error count, a new error beats a clearing write
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      errCount_q <= 16'h0000;
    end else if (anyErr) begin
      if (wrPend_q && wrAddr_q == rzh_pkg::REG_ERRCNT) begin
        errCount_q <= 16'h0001;
      end else if (errCount_q != 16'hffff) begin
        errCount_q <= errCount_q + 16'h0001;
      end
    end else if (wrPend_q && wrAddr_q == rzh_pkg::REG_ERRCNT) begin
      errCount_q <= 16'h0000;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

/* File: verification/rzh_hub_properties.sv */
/*
  pin-level checks of the repeater hub.
  assumes the bit period stays at its reset value of 4 clocks.
*/
`timescale 1ns/1ps

module rzh_hub_properties #(
  parameter int unsigned ERR_PULSE_CYCLES = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic duplexSelect,
  input wire logic centerTxEnable,
  input wire logic [6:0] satPortTxEnable,
  input wire logic activityMonitor,
  input wire logic [7:0] portRxActivity,
  input wire logic errorMonitorN
);
  // 52 bit periods of 4 clocks
  localparam int LAG_MAX = 208;
  logic [31:0] lowLen_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) lowLen_q <= 32'h0;
    else if (errorMonitorN) lowLen_q <= 32'h0;
    else lowLen_q <= lowLen_q + 32'h1;
  end
  chk_reset_quiet: assert property ($rose(nrst) |-> !centerTxEnable && satPortTxEnable == 7'h00)
    else $error("sending right after reset");
  chk_sat_equal: assert property (satPortTxEnable == 7'h00 || satPortTxEnable == 7'h7f)
    else $error("satellite enables differ");
  chk_down_source: assert property ($rose(satPortTxEnable[0]) |-> portRxActivity[0] && activityMonitor)
    else $error("downstream send without center packet");
  chk_up_source: assert property ($rose(centerTxEnable) |-> portRxActivity[7:1] != 7'h00)
    else $error("upstream send without satellite packet");
  chk_one_sat: assert property ($onehot0(portRxActivity[7:1]))
    else $error("two satellites served");
  chk_half_excl: assert property (!duplexSelect |-> !(centerTxEnable && satPortTxEnable[0]))
    else $error("both directions in half duplex");
  chk_activity_any: assert property (portRxActivity != 8'h00 |-> activityMonitor)
    else $error("activity output low while receiving");
  chk_lag_bound: assert property ($rose(portRxActivity[0]) |-> ##[1:LAG_MAX] (satPortTxEnable[0] || !errorMonitorN))
    else $error("downstream lag too long");
  chk_err_length: assert property ($rose(errorMonitorN) |-> lowLen_q == ERR_PULSE_CYCLES)
    else $error("error pulse length wrong");
  chk_err_stops: assert property ($fell(errorMonitorN) && !duplexSelect |-> !centerTxEnable && !satPortTxEnable[0])
    else $error("still sending after error");
  cover property ($rose(satPortTxEnable[0]));
  cover property ($rose(centerTxEnable));
  cover property (centerTxEnable && satPortTxEnable[0]);
  cover property ($fell(errorMonitorN));
endmodule

bind rzh_repeater_hub rzh_hub_properties #(.ERR_PULSE_CYCLES(ERR_PULSE_CYCLES)) chk (
  .clock(clock),
  .nrst(nrst),
  .duplexSelect(duplexSelect),
  .centerTxEnable(centerTxEnable),
  .satPortTxEnable(satPortTxEnable),
  .activityMonitor(activityMonitor),
  .portRxActivity(portRxActivity),
  .errorMonitorN(errorMonitorN)
);

/* File: verification/rzh_line_model.sv */
/*
  far side of the hub lines: center and satellite senders.
  assumes the hub samples the lines on the rising clock edge.
*/
`timescale 1ns/1ps

module rzh_line_model #(
  parameter int P = 4
) (
  input wire logic clock,
  output logic centerRxData,
  output logic [6:0] satPortRxData
);
  localparam logic [7:0] PKT = 8'hb5;
  // idle lines rest low
  logic [7:0] ln = 8'h00;
  assign centerRxData = ln[0];
  assign satPortRxData = ln[7:1];
  // same packet on every masked line; ones after the first shifted by skew
  task automatic send(input logic [7:0] mask, input int skew);
    int s;
    int c;
    int o;
    bit lv;
    for (s = 0; s < 16; s++) begin
      for (c = 0; c < P; c++) begin
        o = (s == 0) ? 0 : skew;
        lv = s < 8 && PKT[7 - s] && c >= o && c < o + P / 2;
        @(posedge clock);
        ln <= lv ? mask : 8'h00;
      end
    end
  endtask
endmodule

/* File: verification/rzh_repeater_hub_test.sv */
/*
  self-checking bench: line packets in both directions and register access.
  assumes the bit period stays at its reset value.
*/
`timescale 1ns/1ps
`define CHK(a, b) check((a) === (b))

module rzh_repeater_hub_test;
  localparam int P = int'(rzh_pkg::BIT_PERIOD_RST);
  // five ones in the test packet
  localparam int HI = 5 * P / 2;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic duplexSelect = 1'b0;
  logic hready, hresp, centerRxData, centerTxData, centerTxEnable, satSharedTxData, activityMonitor, errorMonitorN;
  logic [6:0] satPortRxData, satPortTxEnable;
  logic [7:0] portRxActivity, actSeen;
  logic [31:0] hrdata, rd;
  int errorCnt = 0, nCompared = 0, cyc = 0, dnHigh, upHigh, errLow, lag;
  bit txSeen;
  always #10 clock = ~clock;
  rzh_repeater_hub #(.ERR_PULSE_CYCLES(8)) dut (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .duplexSelect(duplexSelect), .centerRxData(centerRxData),
    .centerTxData(centerTxData), .centerTxEnable(centerTxEnable), .satPortRxData(satPortRxData),
    .satPortTxEnable(satPortTxEnable), .satSharedTxData(satSharedTxData), .activityMonitor(activityMonitor),
    .portRxActivity(portRxActivity), .errorMonitorN(errorMonitorN));
  rzh_line_model #(.P(P)) pm (.clock(clock), .centerRxData(centerRxData), .satPortRxData(satPortRxData));
  task automatic check(input bit ok);
    nCompared++;
    if (!ok) begin
      errorCnt++;
      $display("BAD %0t value mismatch", $time);
    end
  endtask
  task automatic printVerdict;
    if (errorCnt == 0 && nCompared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    if (satSharedTxData === 1'b1) dnHigh++;
    if (centerTxData === 1'b1) upHigh++;
    if (errorMonitorN === 1'b0) errLow++;
    txSeen = txSeen || satPortTxEnable[0] === 1'b1 || centerTxEnable === 1'b1;
    if (!txSeen) lag++;
    actSeen = actSeen | portRxActivity;
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      printVerdict;
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= rzh_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    r = hrdata;
  endtask
  task automatic pkt(input logic d, input logic [7:0] m, input int sk, input int dn, input int up,
                     input logic [7:0] act, input bit e);
    duplexSelect <= d;
    dnHigh = 0;
    upHigh = 0;
    errLow = 0;
    lag = 0;
    txSeen = 0;
    actSeen = 8'h00;
    pm.send(m, sk);
    `CHK(dnHigh, dn);
    if (e) `CHK(upHigh < up, 1'b1);
    if (!e) `CHK(upHigh, up);
    `CHK(actSeen, act);
    `CHK(errLow, e ? 8 : 0);
    if (dn + up > 0) `CHK(lag < 8 * P && lag <= 52 * P, 1'b1);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    `CHK(satPortTxEnable, 7'h00);
    `CHK(errorMonitorN, 1'b1);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    bus(1'b0, rzh_pkg::REG_CTRL, 32'h0, rd);
    `CHK(rd, 32'h1);
    bus(1'b0, rzh_pkg::REG_BAUD, 32'h0, rd);
    `CHK(rd, 32'h4);
    bus(1'b0, 8'h20, 32'h0, rd);
    `CHK(rd, 32'h0);
    pkt(1'b0, 8'h01, 0, HI, 0, 8'h01, 1'b0);
    pkt(1'b0, 8'h08, 0, 0, HI, 8'h08, 1'b0);
    pkt(1'b0, 8'h24, 0, 0, HI, 8'h04, 1'b0);
    pkt(1'b0, 8'h03, 0, HI, 0, 8'h01, 1'b0);
    pkt(1'b1, 8'h03, 0, HI, HI, 8'h03, 1'b0);
    pkt(1'b0, 8'h80, 1, 0, HI, 8'h80, 1'b0);
    pkt(1'b0, 8'h80, 2, 0, HI, 8'h80, 1'b1);
    bus(1'b0, rzh_pkg::REG_ERRCNT, 32'h0, rd);
    `CHK(rd, 32'h1);
    bus(1'b1, rzh_pkg::REG_ERRCNT, 32'h0, rd);
    bus(1'b0, rzh_pkg::REG_ERRCNT, 32'h0, rd);
    `CHK(rd, 32'h0);
    bus(1'b0, rzh_pkg::REG_STATUS, 32'h0, rd);
    `CHK(rd, 32'h0000_7000);
    printVerdict;
  end
endmodule
